// [hdl/pnl_defines.vh]
`ifndef PNL_DEFINES_VH
`define PNL_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define PNL_CLK_MHZ 50
`define PNL_DEB_US 10000

// ----------------------------------------
// key indexes into the debounced key vector
// ----------------------------------------
`define PNL_NKEYS 10
`define PNL_K_STANDBY 0
`define PNL_K_LOGIC_ON 1
`define PNL_K_LOAD_REW 2
`define PNL_K_UNLOAD 3
`define PNL_K_ONLINE 4
`define PNL_K_RESET 5
`define PNL_K_CHECK 6
`define PNL_K_ADVANCE 7
`define PNL_K_RUN 8
`define PNL_K_SERVICE 9

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define PNL_OFS_CTRL 12'h000
`define PNL_OFS_STAT 12'h004
`define PNL_OFS_DISP 12'h008
`define PNL_CTRL_RST 2'h0
`define PNL_UADDR_W 2

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define PNL_ST_STANDBY 0
`define PNL_ST_LOGIC_ON 1
`define PNL_ST_WPROT 2
`define PNL_ST_START 3
`define PNL_ST_ONLINE 4
`define PNL_ST_MATCH 5
`define PNL_ST_RESET 6
`define PNL_ST_DIAG 7
`define PNL_ST_FAULT 8
`define PNL_ST_LOADING 9
`define PNL_ST_PEND 10

// ----------------------------------------
// display
// ----------------------------------------
`define PNL_TEST_FIRST 8'h01
`define PNL_CODE_RST 8'h00

`endif

// [hdl/pnl_debounce.v]
`timescale 1ns/1ps
`include "pnl_defines.vh"

module pnl_debounce #(
    parameter CYCLES = `PNL_DEB_US * `PNL_CLK_MHZ,
    parameter CW = 20
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // raw key, high while pressed
    input wire key_raw,
    // one-cycle press pulse
    output reg press_q
);
    reg sync1_q;
    reg sync2_q;
    reg stable_q;
    reg [CW-1:0] cnt_q;

    // ----------------------------------------
    // sync, then require a quiet interval before accepting a new level
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            stable_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            press_q <= 1'b0;
        end else begin
            sync1_q <= key_raw;
            sync2_q <= sync1_q;
            press_q <= 1'b0;
            if (sync2_q == stable_q) begin
                cnt_q <= {CW{1'b0}};
            end else if (cnt_q >= CYCLES[CW-1:0] - 1'b1) begin
                cnt_q <= {CW{1'b0}};
                stable_q <= sync2_q;
                press_q <= sync2_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// [hdl/pnl_code_disp.v]
`timescale 1ns/1ps
`include "pnl_defines.vh"

module pnl_code_disp (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // mode and events
    input wire diag_enter,
    input wire advance,
    input wire diag_on,
    input wire fault_on,
    input wire [7:0] fault_code,
    // two bcd digits shown, and selected test
    output reg [7:0] disp_q,
    output reg [7:0] test_q
);
    // bcd step, 99 wraps to 00
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] != 4'h9) begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end else if (v[7:4] != 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = 8'h00;
            end
        end
    endfunction

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_q <= `PNL_TEST_FIRST;
            disp_q <= `PNL_CODE_RST;
        end else begin
            if (diag_enter) begin
                test_q <= `PNL_TEST_FIRST;
            end else if (advance) begin
                test_q <= bcd_inc(test_q);
            end
            if (diag_on) begin
                disp_q <= test_q;
            end else if (fault_on) begin
                disp_q <= fault_code;
            end else begin
                disp_q <= `PNL_CODE_RST;
            end
        end
    end
endmodule

// [hdl/pnl_panel.v]
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pnl_defines.vh"

module pnl_panel #(
    parameter DEB_CYCLES = `PNL_DEB_US * `PNL_CLK_MHZ,
    parameter DEB_CW = 20
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // raw pushbuttons, high while pressed
    input wire [`PNL_NKEYS-1:0] key_raw,
    // transport sensing
    input wire main_power_on,
    input wire ring_sensed,
    input wire tape_start_marker,
    input wire tape_threaded,
    input wire tape_loaded,
    input wire load_done,
    input wire [1:0] host_unit_sel,
    input wire fault_valid,
    input wire [7:0] fault_code,
    // power and host
    output reg logic_power_q,
    output reg online_q,
    output wire write_inhibit,
    // motion commands, one-cycle pulses
    output reg mot_load_q,
    output reg mot_rewind_q,
    output reg mot_unload_q,
    output reg mot_rew_unload_q,
    output reg mot_slow_unload_q,
    output reg mot_halt_q,
    // diagnostics
    output reg run_test_q,
    output reg service_q,
    output wire [7:0] test_num,
    // lamps and display
    output wire standby_lamp,
    output wire logic_on_lamp,
    output wire write_protect_lamp,
    output wire tape_start_lamp,
    output wire online_lamp,
    output wire unit_match_lamp,
    output wire reset_lamp,
    output wire diag_lamp,
    output wire [7:0] disp_code
);
    wire [`PNL_NKEYS-1:0] press;
    reg [`PNL_UADDR_W-1:0] uaddr_q;
    reg fault_q;
    reg diag_q;
    reg loading_q;
    reg pend_q;
    reg [11:0] ph_addr_q;
    reg ph_wr_q;
    wire ph_take;
    wire ph_read;
    wire [31:0] status;
    wire keys_ok;
    wire k_stby;
    wire k_on;
    wire k_ldrw;
    wire k_unld;
    wire k_onl;
    wire k_rst;
    wire k_chk;
    wire k_adv;
    wire k_run;
    wire k_svc;
    wire diag_enter;
    wire logic_off;
    wire [`PNL_UADDR_W-1:0] ctrl_rd;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // a key acts only when enabled and not beaten by reset or standby
    function key_gate;
        input pressed;
        input enable;
        input beaten;
        begin
            key_gate = pressed & enable & ~beaten;
        end
    endfunction

    // register slot of a byte address, 0 when unmapped
    function [1:0] reg_slot;
        input [11:0] a;
        begin
            if (a == `PNL_OFS_CTRL) begin
                reg_slot = 2'h1;
            end else if (a == `PNL_OFS_STAT) begin
                reg_slot = 2'h2;
            end else if (a == `PNL_OFS_DISP) begin
                reg_slot = 2'h3;
            end else begin
                reg_slot = 2'h0;
            end
        end
    endfunction

    // ----------------------------------------
    // key debounce
    // ----------------------------------------
    // one filter per key; the long quiet interval swallows contact bounce
    genvar gi;
    generate
        for (gi = 0; gi < `PNL_NKEYS; gi = gi + 1) begin : g_key
            pnl_debounce #(
                .CYCLES(DEB_CYCLES),
                .CW(DEB_CW)
            ) u_deb (
                .hclk(hclk),
                .hresetn(hresetn),
                .key_raw(key_raw[gi]),
                .press_q(press[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // key gating
    // ----------------------------------------
    // operator keys need logic power and neither on-line nor reset lamp
    assign keys_ok = logic_power_q & ~online_q & ~reset_lamp;
    // reset does nothing with logic off; standby always acts
    assign k_stby = press[`PNL_K_STANDBY];
    assign k_on = press[`PNL_K_LOGIC_ON] & ~logic_power_q;
    assign k_rst = press[`PNL_K_RESET] & logic_power_q;
    assign k_ldrw = key_gate(press[`PNL_K_LOAD_REW], keys_ok, k_stby | k_rst);
    assign k_unld = key_gate(press[`PNL_K_UNLOAD], keys_ok, k_stby | k_rst);
    assign k_onl = key_gate(press[`PNL_K_ONLINE], keys_ok, k_stby | k_rst);
    assign k_chk = key_gate(press[`PNL_K_CHECK], keys_ok, k_stby | k_rst);
    // diagnostic keys act in diagnostics even though the reset lamp is lit
    assign k_adv = key_gate(press[`PNL_K_ADVANCE], diag_q, k_stby | k_rst);
    assign k_run = key_gate(press[`PNL_K_RUN], diag_q, k_stby | k_rst);
    assign k_svc = key_gate(press[`PNL_K_SERVICE], diag_q, k_stby | k_rst);
    // losing main power clears the same state as the standby key
    assign logic_off = k_stby | ~main_power_on;
    assign diag_enter = k_chk & tape_threaded & ~tape_loaded;

    // ----------------------------------------
    // power, line and mode state
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            logic_power_q <= 1'b0;
            online_q <= 1'b0;
            fault_q <= 1'b0;
            diag_q <= 1'b0;
            loading_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            // reset and standby beat any other key pressed in the same cycle
            if (logic_off) begin
                logic_power_q <= 1'b0;
            end else if (k_on) begin
                logic_power_q <= 1'b1;
            end
            // a press landing on the load-done edge goes on-line directly
            if (logic_off || k_rst || fault_valid) begin
                online_q <= 1'b0;
            end else if ((k_onl && tape_loaded) || (pend_q && load_done) ||
                (k_onl && loading_q && load_done)) begin
                online_q <= 1'b1;
            end
            // a fault arriving with the reset press still latches
            if (fault_valid && logic_power_q) begin
                fault_q <= 1'b1;
            end else if (k_rst || logic_off) begin
                fault_q <= 1'b0;
            end
            if (k_rst || logic_off) begin
                diag_q <= 1'b0;
            end else if (diag_enter) begin
                diag_q <= 1'b1;
            end
            // loading marks a load started here, for the pending on-line press
            if (k_ldrw && !tape_loaded && tape_threaded) begin
                loading_q <= 1'b1;
            end else if (load_done || k_rst || logic_off || fault_valid) begin
                loading_q <= 1'b0;
            end
            if (k_onl && loading_q && !load_done) begin
                pend_q <= 1'b1;
            end else if (load_done || k_rst || logic_off || fault_valid) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // motion and diagnostic commands
    // ----------------------------------------
    // pulses last one cycle; the sequencer latches what it needs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mot_load_q <= 1'b0;
            mot_rewind_q <= 1'b0;
            mot_unload_q <= 1'b0;
            mot_rew_unload_q <= 1'b0;
            mot_slow_unload_q <= 1'b0;
            mot_halt_q <= 1'b0;
            run_test_q <= 1'b0;
            service_q <= 1'b0;
        end else begin
            mot_load_q <= k_ldrw & ~tape_loaded & tape_threaded;
            mot_rewind_q <= k_ldrw & tape_loaded;
            mot_unload_q <= k_unld & tape_loaded & tape_start_marker;
            mot_rew_unload_q <= k_unld & tape_loaded & ~tape_start_marker;
            mot_slow_unload_q <= k_unld & ~tape_loaded & tape_threaded;
            mot_halt_q <= k_rst | k_stby;
            run_test_q <= k_run;
            service_q <= k_svc;
        end
    end

    // ----------------------------------------
    // display and test number
    // ----------------------------------------
    // the display lags its sources by one edge
    pnl_code_disp u_disp (
        .hclk(hclk),
        .hresetn(hresetn),
        .diag_enter(diag_enter),
        .advance(k_adv),
        .diag_on(diag_q),
        .fault_on(fault_q),
        .fault_code(fault_code),
        .disp_q(disp_code),
        .test_q(test_num)
    );

    // ----------------------------------------
    // lamps
    // ----------------------------------------
    // all lamps but the two power lamps stay dark with logic off, except a reset lamp latched by a fault arriving in the power-off cycle
    assign standby_lamp = main_power_on & ~logic_power_q;
    assign logic_on_lamp = main_power_on & logic_power_q;
    assign write_protect_lamp = logic_power_q & ~ring_sensed;
    // writes stay blocked without a ring even with the lamp dark
    assign write_inhibit = ~ring_sensed | ~logic_power_q;
    assign tape_start_lamp = logic_power_q & tape_start_marker;
    assign online_lamp = online_q;
    assign unit_match_lamp = logic_power_q & ~diag_q &
        (uaddr_q == host_unit_sel);
    assign reset_lamp = fault_q | diag_q;
    assign diag_lamp = diag_q;

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    // the slave never stalls, so hready only qualifies the address phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ph_take = hsel & htrans[1] & hready;
    assign ph_read = ph_take & ~hwrite;
    // a read right behind a control write must see the new unit address
    assign ctrl_rd = (ph_wr_q && reg_slot(ph_addr_q) == 2'h1) ?
        hwdata[`PNL_UADDR_W-1:0] : uaddr_q;

    // ----------------------------------------
    // status word
    // ----------------------------------------
    assign status[31:11] = 21'h000000;
    assign status[`PNL_ST_STANDBY] = standby_lamp;
    assign status[`PNL_ST_LOGIC_ON] = logic_on_lamp;
    assign status[`PNL_ST_WPROT] = write_protect_lamp;
    assign status[`PNL_ST_START] = tape_start_lamp;
    assign status[`PNL_ST_ONLINE] = online_lamp;
    assign status[`PNL_ST_MATCH] = unit_match_lamp;
    assign status[`PNL_ST_RESET] = reset_lamp;
    assign status[`PNL_ST_DIAG] = diag_lamp;
    assign status[`PNL_ST_FAULT] = fault_q;
    assign status[`PNL_ST_LOADING] = loading_q;
    assign status[`PNL_ST_PEND] = pend_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_addr_q <= 12'h000;
            ph_wr_q <= 1'b0;
            uaddr_q <= `PNL_CTRL_RST;
            hrdata <= 32'h00000000;
        end else begin
            ph_wr_q <= ph_take & hwrite;
            if (ph_take) begin
                ph_addr_q <= haddr;
            end
            // writes land at the end of the data phase
            if (ph_wr_q && reg_slot(ph_addr_q) == 2'h1) begin
                uaddr_q <= hwdata[`PNL_UADDR_W-1:0];
            end
            // read data is captured in the address phase
            if (ph_read) begin
                if (reg_slot(haddr) == 2'h1) begin
                    hrdata <= {30'h00000000, ctrl_rd};
                end else if (reg_slot(haddr) == 2'h2) begin
                    hrdata <= status;
                end else if (reg_slot(haddr) == 2'h3) begin
                    hrdata <= {16'h0000, test_num, disp_code};
                end else begin
                    // unmapped offsets read as zero
                    hrdata <= 32'h00000000;
                end
            end
        end
    end
endmodule

// [tb/pnl_panel_chk.sv]
`timescale 1ns/1ps
// --------------------------
// panel behaviour checks
// --------------------------
module pnl_panel_chk (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // sensing
    input wire main_power_on,
    input wire tape_loaded,
    // state and commands
    input wire logic_power_q,
    input wire online_q,
    input wire write_inhibit,
    input wire mot_load_q,
    input wire mot_rewind_q,
    input wire mot_unload_q,
    input wire mot_halt_q,
    input wire [7:0] test_num,
    input wire [7:0] disp_code,
    // lamps
    input wire standby_lamp,
    input wire logic_on_lamp,
    input wire write_protect_lamp,
    input wire unit_match_lamp,
    input wire reset_lamp,
    input wire diag_lamp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // diag held two cycles with no test step in between
    sequence s_diag_steady;
        diag_lamp ##1 diag_lamp && $stable(test_num);
    endsequence

    a_standby_lamp: assert property (standby_lamp == (main_power_on && !logic_power_q))
        else $error("standby lamp mismatch");
    a_logic_lamp: assert property (logic_on_lamp == (main_power_on && logic_power_q))
        else $error("logic-on lamp mismatch");
    a_wprot_inhibit: assert property (write_protect_lamp |-> write_inhibit)
        else $error("write allowed while protected");
    a_match_diag: assert property (diag_lamp |-> !unit_match_lamp)
        else $error("unit match lit in diagnostics");
    a_diag_reset: assert property (diag_lamp |-> reset_lamp)
        else $error("reset lamp dark in diagnostics");
    a_diag_hold: assert property ($fell(diag_lamp) |-> mot_halt_q || !logic_power_q)
        else $error("diagnostics left without reset");
    a_disp_test: assert property (s_diag_steady |-> disp_code == test_num)
        else $error("display not showing test number");
    a_online_quiet: assert property (online_q && $past(online_q) |-> !mot_load_q && !mot_unload_q)
        else $error("motion key acted while on-line");
    a_rewind_loaded: assert property (mot_rewind_q |-> $past(tape_loaded))
        else $error("rewind without loaded tape");
endmodule

bind pnl_panel pnl_panel_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .main_power_on(main_power_on),
    .tape_loaded(tape_loaded), .logic_power_q(logic_power_q), .online_q(online_q),
    .write_inhibit(write_inhibit), .mot_load_q(mot_load_q), .mot_rewind_q(mot_rewind_q),
    .mot_unload_q(mot_unload_q), .mot_halt_q(mot_halt_q), .test_num(test_num),
    .disp_code(disp_code), .standby_lamp(standby_lamp), .logic_on_lamp(logic_on_lamp),
    .write_protect_lamp(write_protect_lamp), .unit_match_lamp(unit_match_lamp),
    .reset_lamp(reset_lamp), .diag_lamp(diag_lamp)
);

// [tb/pnl_operator.sv]
`timescale 1ns/1ps
// --------------------------
// operator at the keys
// --------------------------
module pnl_operator (
    // clock
    input wire hclk,
    // keys, high while pressed
    output logic [9:0] key_raw
);
    initial key_raw = 10'h000;

    // a short contact bounce first, so a glitch must not count as a press
    task press(input int k);
        @(posedge hclk) key_raw[k] <= 1'b1;
        @(posedge hclk) key_raw[k] <= 1'b0;
        @(posedge hclk) key_raw[k] <= 1'b1;
        repeat (12) @(posedge hclk);
        key_raw[k] <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask
endmodule

// [tb/tape_transport_panel_control_tb_top.sv]
`timescale 1ns/1ps
module tape_transport_panel_control_tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, main_power_on = 1, ring_sensed = 1;
    logic tape_start_marker = 0, tape_threaded = 0, tape_loaded = 0, load_done = 0;
    logic fault_valid = 0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0, host_unit_sel = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    logic [7:0] fault_code = 8'h00, seen = 8'h00;
    wire [31:0] hrdata;
    wire [9:0] key_raw;
    wire [7:0] test_num, disp_code;
    wire hreadyout, hresp, logic_power_q, online_q, write_inhibit, mot_load_q, mot_rewind_q;
    wire mot_unload_q, mot_rew_unload_q, mot_slow_unload_q, mot_halt_q, run_test_q, service_q;
    wire standby_lamp, logic_on_lamp, write_protect_lamp, tape_start_lamp, online_lamp;
    wire unit_match_lamp, reset_lamp, diag_lamp;
    int num_errors = 0, compares = 0;
    // {key, threaded, loaded, at start, 0, expected pulses}
    logic [15:0] rows [7] = '{
        16'h2c02,   // rewind
        16'h3e04,   // unload at start
        16'h3c08,   // rewind then unload
        16'h3810,   // slow unload
        16'h9800,   // service outside diagnostics
        16'h8800,   // run outside diagnostics
        16'h2801};  // load

    pnl_panel #(.DEB_CYCLES(4)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_raw(key_raw),
        .main_power_on(main_power_on), .ring_sensed(ring_sensed),
        .tape_start_marker(tape_start_marker), .tape_threaded(tape_threaded),
        .tape_loaded(tape_loaded), .load_done(load_done), .host_unit_sel(host_unit_sel),
        .fault_valid(fault_valid), .fault_code(fault_code), .logic_power_q(logic_power_q),
        .online_q(online_q), .write_inhibit(write_inhibit), .mot_load_q(mot_load_q),
        .mot_rewind_q(mot_rewind_q), .mot_unload_q(mot_unload_q),
        .mot_rew_unload_q(mot_rew_unload_q), .mot_slow_unload_q(mot_slow_unload_q),
        .mot_halt_q(mot_halt_q), .run_test_q(run_test_q), .service_q(service_q),
        .test_num(test_num), .standby_lamp(standby_lamp), .logic_on_lamp(logic_on_lamp),
        .write_protect_lamp(write_protect_lamp), .tape_start_lamp(tape_start_lamp),
        .online_lamp(online_lamp), .unit_match_lamp(unit_match_lamp),
        .reset_lamp(reset_lamp), .diag_lamp(diag_lamp), .disp_code(disp_code));

    pnl_operator u_op (.hclk(hclk), .key_raw(key_raw));

    initial forever #10 hclk = ~hclk;

    always @(posedge hclk) begin
        seen <= seen | {service_q, run_test_q, mot_halt_q, mot_slow_unload_q,
                        mot_rew_unload_q, mot_unload_q, mot_rewind_q, mot_load_q};
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task key(input int k);
        @(negedge hclk) seen = 8'h00;
        u_op.press(k);
    endtask

    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task end_of_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test;
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        main_power_on <= 1'b0;
        @(posedge hclk);
        chk(standby_lamp, 1'b0);
        key(1);
        chk(logic_power_q, 1'b0);
        @(posedge hclk) main_power_on <= 1'b1;
        key(1);
        chk(logic_on_lamp, 1'b1);
        chk(standby_lamp, 1'b0);
        $display("test power done");
        ahb(1'b1, 12'h000, 32'h2);
        ahb(1'b1, 12'h00c, 32'h3);
        ahb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h2);
        chk(hresp, 1'b0);
        ahb(1'b0, 12'h004, 32'h0);
        chk(rd[1:0], 2'h2);
        host_unit_sel <= 2'h2;
        ring_sensed <= 1'b0;
        tape_start_marker <= 1'b1;
        @(posedge hclk);
        chk(unit_match_lamp, 1'b1);
        chk(write_protect_lamp, 1'b1);
        chk(write_inhibit, 1'b1);
        chk(tape_start_lamp, 1'b1);
        ring_sensed <= 1'b1;
        @(posedge hclk);
        chk(write_inhibit, 1'b0);
        $display("test lamps done");
        for (int i = 0; i < 7; i++) begin
            @(posedge hclk) {tape_threaded, tape_loaded, tape_start_marker} <= rows[i][11:9];
            key(rows[i][15:12]);
            chk(seen, rows[i][7:0]);
        end
        $display("test rows done");
        key(4);
        chk(online_q, 1'b0);
        tape_loaded <= 1'b1;
        load_done <= 1'b1;
        @(posedge hclk) load_done <= 1'b0;
        @(posedge hclk);
        chk(online_q, 1'b1);
        chk(online_lamp, 1'b1);
        key(2);
        chk(seen, 8'h00);
        key(5);
        chk(online_q, 1'b0);
        chk(seen, 8'h20);
        key(4);
        chk(online_q, 1'b1);
        key(5);
        chk(online_lamp, 1'b0);
        $display("test online done");
        key(6);
        chk(diag_lamp, 1'b0);
        @(posedge hclk) tape_loaded <= 1'b0;
        key(6);
        chk(diag_lamp, 1'b1);
        chk(reset_lamp, 1'b1);
        chk(unit_match_lamp, 1'b0);
        chk(disp_code, 8'h01);
        key(2);
        chk(seen, 8'h00);
        key(7);
        chk(test_num, 8'h02);
        ahb(1'b0, 12'h008, 32'h0);
        chk(rd[15:0], 16'h0202);
        key(8);
        chk(seen, 8'h40);
        key(9);
        chk(seen, 8'h80);
        key(5);
        chk(diag_lamp, 1'b0);
        chk(reset_lamp, 1'b0);
        $display("test diagnostics done");
        fault_code <= 8'h14;
        fault_valid <= 1'b1;
        @(posedge hclk) fault_valid <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(reset_lamp, 1'b1);
        chk(disp_code, 8'h14);
        key(2);
        chk(seen, 8'h00);
        key(5);
        chk(reset_lamp, 1'b0);
        key(0);
        chk(logic_power_q, 1'b0);
        chk(standby_lamp, 1'b1);
        $display("test fault and standby done");
        hresetn <= 1'b0;
        @(posedge hclk);
        chk(test_num, 8'h01);
        chk(disp_code, 8'h00);
        chk(standby_lamp, 1'b1);
        hresetn <= 1'b1;
        ahb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        end_of_test;
    end
endmodule
